// File: src/ddr2_cmd_params.svh
/*
 * Constants for the command and clock-enable sequencer that drives a
 * DDR2 memory device: command pin encodings, address bit positions and
 * timing counts.
 * Assumes inclusion by the sequencer, its checker and the memory model only.
 */
`ifndef DDR2_CMD_PARAMS_SVH
`define DDR2_CMD_PARAMS_SVH

// Command pin levels {cs_n, ras_n, cas_n, we_n}
`define PIN_MRS 4'h0
`define PIN_REF 4'h1
`define PIN_PRE 4'h2
`define PIN_ACT 4'h3
`define PIN_WR 4'h4
`define PIN_RD 4'h5
`define PIN_NOP 4'h7
`define PIN_DESEL 4'hf

// Address bit that selects auto precharge or precharge of all banks
`define AP_BIT 10
// Termination enable bits in the first extended mode register
`define ODT_EN_BIT_A 2
`define ODT_EN_BIT_B 6

// Clock-enable hold in link clocks (three registered edges)
`define CKE_HOLD_CLOCKS 3
// Self-refresh exit to read, link clocks
`define XSRD_CLOCKS 200
// Self-refresh exit to any command other than read or low-power entry, link clocks
`define XSNR_CLOCKS 20
// Link clock divider: half period in system clocks
`define LINK_HALF_DIV 2

`endif

// File: src/ddr2_cmd_pkg.sv
/*
 * Types shared by the DDR2 command sequencer: request opcodes, the pin
 * bundle driven toward the memory and the request bundle from the user.
 * Assumes the constants header is available on the include path.
 */
package ddr2_cmd_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_MRS = 4'h1,
        OP_REF = 4'h2,
        OP_PRE = 4'h3,
        OP_PREALL = 4'h4,
        OP_ACT = 4'h5,
        OP_WR = 4'h6,
        OP_RD = 4'h7,
        OP_PD_ENTER = 4'h8,
        OP_SR_ENTER = 4'h9,
        OP_EXIT = 4'ha
    } op_t;

    typedef struct packed {
        op_t op;
        logic [2:0] bank;
        logic [15:0] addr;
        logic auto_pre;
    } req_t;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] a;
    } pins_t;
endpackage : ddr2_cmd_pkg

// File: src/ddr2_cmd_seq.sv
/*
 * Host-side command and clock-enable sequencer for a DDR2 memory device.
 * Takes one request at a time, checks it against the power state and the
 * open-row state, and drives command pins, clock enable, termination and
 * write data mask toward the device on a link clock it divides itself.
 * Assumes the user holds a request until req_ready; no other master.
 */
`timescale 1ns/1ps
`include "ddr2_cmd_params.svh"

module ddr2_cmd_seq #(
    parameter int BUSY_CLOCKS = 8,
    parameter int DM_WIDTH = 2
) (
    // System
    input wire logic sys_clk,
    input wire logic resetn,
    // User request side
    input wire ddr2_cmd_pkg::req_t req,
    input wire logic req_valid,
    input wire logic [DM_WIDTH-1:0] wr_byte_en,
    input wire logic calib_active,
    input wire logic odt_enable,
    input wire logic odt_want,
    output logic req_ready,
    output logic req_reject,
    output logic in_power_down,
    output logic in_self_refresh,
    output logic rows_open,
    // Memory side
    output logic link_clk,
    output ddr2_cmd_pkg::pins_t pins,
    output logic odt,
    output logic [DM_WIDTH-1:0] dm
);
    import ddr2_cmd_pkg::*;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_PD = 4'b0010,
        ST_SR = 4'b0100,
        ST_WAIT = 4'b1000
    } state_t;

    localparam logic [2:0] HALF = 3'(`LINK_HALF_DIV - 1);

    state_t state_q;
    logic [2:0] div_q;
    logic link_clk_q;
    logic rise;
    logic [7:0] hold_q;
    logic [7:0] busy_q;
    logic [7:0] xs_q;
    logic [7:0] open_q;
    pins_t pins_q;
    logic odt_q;
    logic [DM_WIDTH-1:0] dm_q;
    logic ready_q;
    logic reject_q;
    logic ok;
    logic rows_open_q;

    // Pin pattern for a request opcode
    function automatic logic [3:0] pin_code(input op_t op);
        unique case (op)
            OP_MRS: pin_code = `PIN_MRS;
            OP_REF, OP_SR_ENTER: pin_code = `PIN_REF;
            OP_PRE, OP_PREALL: pin_code = `PIN_PRE;
            OP_ACT: pin_code = `PIN_ACT;
            OP_WR: pin_code = `PIN_WR;
            OP_RD: pin_code = `PIN_RD;
            default: pin_code = `PIN_NOP;
        endcase
    endfunction : pin_code

    // Link clock divider; commands change on the falling half
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div_q <= 3'h0;
            link_clk_q <= 1'b0;
        end else if (div_q == HALF) begin
            div_q <= 3'h0;
            link_clk_q <= ~link_clk_q;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // Two system clocks before the link clock rises, as it falls, the pins are updated
    assign rise = (div_q == HALF) && link_clk_q;

    // Legality of the present request in the present state
    always_comb begin
        ok = 1'b0;
        unique case (state_q)
            ST_RUN, ST_WAIT: begin
                unique case (req.op)
                    OP_PD_ENTER: ok = (hold_q == 8'h0) && (busy_q == 8'h0)
                        && !calib_active;
                    OP_SR_ENTER: ok = (hold_q == 8'h0) && (busy_q == 8'h0)
                        && (open_q == 8'h0) && !calib_active
                        && !odt_want;
                    OP_EXIT: ok = 1'b0;
                    OP_ACT: ok = (busy_q == 8'h0) && !open_q[req.bank];
                    OP_RD, OP_WR: ok = (busy_q == 8'h0) && open_q[req.bank];
                    default: ok = (busy_q == 8'h0);
                endcase
                // Exit wait: reads and low power only after the full delay
                if (state_q == ST_WAIT && xs_q != 8'h0
                    && (req.op inside {OP_RD, OP_PD_ENTER, OP_SR_ENTER}
                    || (req.op != OP_NOP
                    && xs_q > 8'(`XSRD_CLOCKS - `XSNR_CLOCKS)))) begin
                    ok = 1'b0;
                end
            end
            ST_PD, ST_SR: ok = (req.op == OP_EXIT)
                && (hold_q == 8'h0);
            default: ok = 1'b0;
        endcase
    end

    // Request handshake and command issue on the link clock fall
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ready_q <= 1'b0;
            reject_q <= 1'b0;
            pins_q <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                we_n: 1'b1, ba: 3'h0, a: 16'h0};
            state_q <= ST_PD;
            dm_q <= '1;
        end else begin
            ready_q <= 1'b0;
            reject_q <= 1'b0;
            if (rise) begin
                // Default every edge to no-op in run, deselect in other states, keeping the clock enable
                pins_q.cs_n <= (state_q != ST_RUN);
                {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= 3'h7;
                dm_q <= '1;
                // Exit wait ends once the read delay has run out
                if (state_q == ST_WAIT && xs_q == 8'h0) begin
                    state_q <= ST_RUN;
                end
                if (req_valid && !ready_q) begin
                    ready_q <= 1'b1;
                    reject_q <= !ok;
                    if (ok) begin
                        unique case (req.op)
                            OP_PD_ENTER: begin
                                pins_q.cke <= 1'b0;
                                state_q <= ST_PD;
                            end
                            OP_SR_ENTER: begin
                                pins_q.cke <= 1'b0;
                                {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n,
                                    pins_q.we_n} <= `PIN_REF;
                                state_q <= ST_SR;
                            end
                            OP_EXIT: begin
                                pins_q.cke <= 1'b1;
                                state_q <= (state_q == ST_SR) ? ST_WAIT
                                    : ST_RUN;
                            end
                            OP_NOP: begin
                            end
                            default: begin
                                {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n,
                                    pins_q.we_n} <= pin_code(req.op);
                                pins_q.ba <= req.bank;
                                pins_q.a <= req.addr;
                                pins_q.a[`AP_BIT] <= (req.op == OP_PREALL)
                                    || (req.op == OP_ACT
                                    ? req.addr[`AP_BIT] : req.auto_pre);
                                if (req.op == OP_MRS || req.op == OP_REF) begin
                                    pins_q.a[`AP_BIT] <= req.addr[`AP_BIT];
                                end
                                if (req.op == OP_WR) begin
                                    dm_q <= ~wr_byte_en;
                                end
                            end
                        endcase
                    end
                end
            end
        end
    end

    // Clock-enable hold and exit-wait counters, in link clocks
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hold_q <= 8'(`CKE_HOLD_CLOCKS);
            xs_q <= 8'h0;
        end else if (rise) begin
            if (req_valid && !ready_q && ok && (req.op == OP_PD_ENTER
                || req.op == OP_SR_ENTER || req.op == OP_EXIT)) begin
                hold_q <= 8'(`CKE_HOLD_CLOCKS);
            end else if (hold_q != 8'h0) begin
                hold_q <= hold_q - 8'h1;
            end
            if (state_q == ST_SR && req_valid && !ready_q && ok) begin
                xs_q <= 8'(`XSRD_CLOCKS);
            end else if (xs_q != 8'h0) begin
                xs_q <= xs_q - 8'h1;
            end
        end
    end

    // Busy window after burst, mode set, precharge, refresh or activate; open-row tracking
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            busy_q <= 8'h0;
            open_q <= 8'h0;
        end else if (rise) begin
            if (req_valid && !ready_q && ok && state_q != ST_PD
                && state_q != ST_SR) begin
                unique case (req.op)
                    OP_ACT: open_q[req.bank] <= 1'b1;
                    OP_PRE: open_q[req.bank] <= 1'b0;
                    OP_PREALL: open_q <= 8'h0;
                    OP_RD, OP_WR: begin
                        if (req.auto_pre) begin
                            open_q[req.bank] <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
                if (req.op inside {OP_MRS, OP_PRE, OP_PREALL, OP_RD, OP_WR,
                    OP_REF, OP_ACT}) begin
                    busy_q <= 8'(BUSY_CLOCKS);
                end else if (busy_q != 8'h0) begin
                    busy_q <= busy_q - 8'h1;
                end
            end else if (busy_q != 8'h0) begin
                busy_q <= busy_q - 8'h1;
            end
        end
    end

    // Termination follows the user in run and power-down, off otherwise
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            odt_q <= 1'b0;
        end else if (state_q == ST_SR || state_q == ST_WAIT) begin
            odt_q <= 1'b0;
        end else begin
            odt_q <= odt_enable & odt_want;
        end
    end

    // Any open row, registered for the status output
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rows_open_q <= 1'b0;
        end else begin
            rows_open_q <= |open_q;
        end
    end

    assign link_clk = link_clk_q;
    assign pins = pins_q;
    assign odt = odt_q;
    assign dm = dm_q;
    assign req_ready = ready_q;
    assign req_reject = reject_q;
    // One-hot state bits are flops, so status needs no gates
    assign in_power_down = state_q[1];
    assign in_self_refresh = state_q[2];
    assign rows_open = rows_open_q;
endmodule : ddr2_cmd_seq

// File: verif/ddr2_cmd_seq_sva.sv
/*
 * Port checker for the DDR2 command sequencer.
 * Assumes binding onto every sequencer instance, one system clock.
 */
`timescale 1ns/1ps
`include "ddr2_cmd_params.svh"
module ddr2_cmd_seq_chk #(
    parameter int BUSY_CLOCKS = 8,
    parameter int DM_WIDTH = 2
) (
    // System
    input wire logic sys_clk,
    input wire logic resetn,
    // Observed ports
    input wire logic calib_active,
    input wire logic req_ready,
    input wire logic req_reject,
    input wire logic in_self_refresh,
    input wire logic rows_open,
    input wire logic link_clk,
    input wire ddr2_cmd_pkg::pins_t pins,
    input wire logic odt,
    input wire logic [DM_WIDTH-1:0] dm
);
    import ddr2_cmd_pkg::*;
    logic [3:0] cmd;
    logic idle;
    // Strobe group and idle command
    assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    assign idle = pins.cs_n || (cmd == `PIN_NOP);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_reject_has_ready: assert property (req_reject |-> req_ready)
        else $error("reject without ready");
    a_ready_spaced: assert property (req_ready |=> !req_ready[*3])
        else $error("ready pulses too close");
    a_pins_at_edge: assert property ($rose(link_clk) |-> $stable(pins))
        else $error("pins moved at link edge");
    a_mask_on_write: assert property (dm != '1 |-> cmd == `PIN_WR)
        else $error("mask open outside write");
    a_cke_held: assert property ($changed(pins.cke) |=> $stable(pins.cke)[*8])
        else $error("clock enable not held");
    a_low_cke_idle: assert property (!pins.cke[*6] |-> idle)
        else $error("command while clock enable low");
    a_sr_no_odt: assert property (in_self_refresh |-> !odt)
        else $error("termination in self refresh");
    a_sr_banks_idle: assert property (in_self_refresh |-> !rows_open)
        else $error("row open in self refresh");
    a_calib_cke: assert property (calib_active && pins.cke |=> pins.cke)
        else $error("clock enable dropped in calibration");
    // Main scenarios
    c_taken: cover property (req_ready && !req_reject);
    c_refused: cover property (req_reject);
    c_self_refresh: cover property (in_self_refresh);
endmodule : ddr2_cmd_seq_chk

bind ddr2_cmd_seq ddr2_cmd_seq_chk #(
    .BUSY_CLOCKS(BUSY_CLOCKS),
    .DM_WIDTH(DM_WIDTH)
) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .calib_active(calib_active),
    .req_ready(req_ready), .req_reject(req_reject),
    .in_self_refresh(in_self_refresh), .rows_open(rows_open),
    .link_clk(link_clk), .pins(pins), .odt(odt), .dm(dm)
);

// File: verif/ddr2_mem_model.sv
/*
 * Behavioural memory device decoding the sequencer's command pins.
 * Assumes pins are launched ahead of each rising link clock.
 */
`timescale 1ns/1ps
`include "ddr2_cmd_params.svh"
module ddr2_mem_model #(
    parameter int DM_WIDTH = 2
) (
    // Link
    input wire logic link_clk,
    input wire ddr2_cmd_pkg::pins_t pins,
    input wire logic odt,
    input wire logic [DM_WIDTH-1:0] dm,
    // Status
    output logic [7:0] err_q,
    output logic [7:0] open_q,
    output logic [DM_WIDTH-1:0] wr_dm_q
);
    import ddr2_cmd_pkg::*;
    logic cke_q;
    logic sr_q;
    logic [3:0] cmd;
    logic idle;
    // Strobe group; deselect ignores the other strobes
    assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    assign idle = pins.cs_n || (cmd == `PIN_NOP);
    initial begin
        err_q = 8'h00;
        open_q = 8'h00;
        cke_q = 1'b0;
        sr_q = 1'b0;
    end
    // Decode each registered edge from strobes and clock enable
    always @(posedge link_clk) begin
        cke_q <= pins.cke;
        if (sr_q && odt) err_q <= err_q + 8'h01;
        if (cke_q && pins.cke) begin
            case (cmd)
                `PIN_ACT: begin
                    if (open_q[pins.ba]) err_q <= err_q + 8'h01;
                    open_q[pins.ba] <= 1'b1;
                end
                `PIN_PRE: begin
                    if (pins.a[`AP_BIT]) open_q <= 8'h00;
                    else open_q[pins.ba] <= 1'b0;
                end
                `PIN_WR, `PIN_RD: begin
                    if (!open_q[pins.ba]) err_q <= err_q + 8'h01;
                    if (pins.a[`AP_BIT]) open_q[pins.ba] <= 1'b0;
                    if (cmd == `PIN_WR) wr_dm_q <= dm;
                end
                `PIN_MRS, `PIN_REF, `PIN_NOP: ;
                default: if (!pins.cs_n) err_q <= err_q + 8'h01;
            endcase
        end else if (cke_q) begin
            // Falling enable: self refresh on a refresh command, else power-down
            if (!pins.cs_n && cmd == `PIN_REF) begin
                sr_q <= 1'b1;
                if (open_q != 8'h00) err_q <= err_q + 8'h01;
            end else if (!idle) err_q <= err_q + 8'h01;
        end else if (pins.cke) begin
            // Rising enable leaves either low-power state
            sr_q <= 1'b0;
            if (!idle) err_q <= err_q + 8'h01;
        end // Low enable: pins ignored, no refresh
    end
endmodule : ddr2_mem_model

// File: verif/test_ddr2_cmd_seq.sv
/*
 * Self-checking bench: sequencer driving a behavioural memory model.
 * Assumes the sequencer divides and drives its own link clock.
 */
`timescale 1ns/1ps
module test_ddr2_cmd_seq;
    import ddr2_cmd_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    req_t req = '0;
    logic req_valid = 1'b0;
    logic [1:0] wr_byte_en = 2'h3;
    logic calib_active = 1'b0;
    logic odt_enable = 1'b1;
    logic odt_want = 1'b0;
    logic req_ready, req_reject, in_power_down, in_self_refresh;
    logic rows_open, link_clk, odt, rej;
    pins_t pins;
    logic [1:0] dm, wr_dm;
    logic [7:0] err, open_rows;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    ddr2_cmd_seq #(.BUSY_CLOCKS(8), .DM_WIDTH(2)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .req(req),
        .req_valid(req_valid), .wr_byte_en(wr_byte_en),
        .calib_active(calib_active), .odt_enable(odt_enable),
        .odt_want(odt_want), .req_ready(req_ready),
        .req_reject(req_reject), .in_power_down(in_power_down),
        .in_self_refresh(in_self_refresh), .rows_open(rows_open),
        .link_clk(link_clk), .pins(pins), .odt(odt), .dm(dm)
    );
    ddr2_mem_model #(.DM_WIDTH(2)) u_mem (
        .link_clk(link_clk), .pins(pins), .odt(odt), .dm(dm),
        .err_q(err), .open_q(open_rows), .wr_dm_q(wr_dm)
    );
    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_lk(input int n);
        repeat (n) @(posedge link_clk);
        @(negedge sys_clk);
    endtask : wait_lk
    // One request held until ready, then judged accepted or refused
    task automatic send(input op_t o, input logic [2:0] ba,
            input logic ap, input logic exp_rej);
        int n;
        @(negedge sys_clk);
        req = '{op: o, bank: ba, addr: 16'h0123, auto_pre: ap};
        req_valid = 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        rej = req_reject;
        req_valid = 1'b0;
        chk(req_ready, 1'b1);
        chk(rej, exp_rej);
        if (exp_rej === 1'b0) wait_lk(10);
    endtask : send
    task automatic t_power_up();
        send(OP_EXIT, 3'h0, 1'b0, 1'b1);
        send(OP_ACT, 3'h1, 1'b0, 1'b1);
        chk(in_power_down, 1'b1);
        wait_lk(4);
        send(OP_EXIT, 3'h0, 1'b0, 1'b0);
        chk(in_power_down, 1'b0);
        chk(pins.cke, 1'b1);
    endtask : t_power_up
    task automatic t_banks();
        send(OP_MRS, 3'h1, 1'b0, 1'b0);
        send(OP_REF, 3'h0, 1'b0, 1'b0);
        send(OP_ACT, 3'h1, 1'b0, 1'b0);
        send(OP_ACT, 3'h1, 1'b0, 1'b1);
        send(OP_RD, 3'h2, 1'b0, 1'b1);
        wr_byte_en = 2'h1;
        send(OP_WR, 3'h1, 1'b0, 1'b0);
        chk(wr_dm, 2'h2);
        chk(dm, 2'h3);
        send(OP_RD, 3'h1, 1'b0, 1'b0);
        chk(open_rows, 8'h02);
    endtask : t_banks
    task automatic t_power_down();
        calib_active = 1'b1;
        send(OP_PD_ENTER, 3'h0, 1'b0, 1'b1);
        calib_active = 1'b0;
        send(OP_PD_ENTER, 3'h0, 1'b0, 1'b0);
        chk(in_power_down, 1'b1);
        chk(rows_open, 1'b1);
        send(OP_WR, 3'h1, 1'b0, 1'b1);
        send(OP_EXIT, 3'h0, 1'b0, 1'b0);
    endtask : t_power_down
    task automatic t_self_refresh();
        send(OP_SR_ENTER, 3'h0, 1'b0, 1'b1);
        send(OP_PRE, 3'h1, 1'b0, 1'b0);
        send(OP_PREALL, 3'h0, 1'b0, 1'b0);
        chk(rows_open, 1'b0);
        odt_want = 1'b1;
        send(OP_SR_ENTER, 3'h0, 1'b0, 1'b1);
        odt_want = 1'b0;
        send(OP_SR_ENTER, 3'h0, 1'b0, 1'b0);
        chk(in_self_refresh, 1'b1);
        send(OP_EXIT, 3'h0, 1'b0, 1'b0);
        chk(in_self_refresh, 1'b0);
        send(OP_ACT, 3'h3, 1'b0, 1'b1);
        wait_lk(12);
        send(OP_ACT, 3'h3, 1'b0, 1'b0);
        send(OP_RD, 3'h3, 1'b1, 1'b1);
        wait_lk(180);
        send(OP_RD, 3'h3, 1'b1, 1'b0);
        chk(open_rows, 8'h00);
    endtask : t_self_refresh
    task automatic give_verdict();
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // Reset, then the scenarios in order
    initial begin
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        t_power_up();
        t_banks();
        t_power_down();
        t_self_refresh();
        chk(err, 8'h00);
        give_verdict();
    end
endmodule : test_ddr2_cmd_seq
